// ==== hdl/sdl_buf2.sv ====
// two-entry valid/ready buffer between frame capture and converter update
`timescale 1ns/1ps
`default_nettype none
module sdl_buf2 #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  // draining side
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign s_ready = (cnt_q != (PW+1)'(DEPTH));
  assign m_valid = (cnt_q != '0);
  assign m_data = mem_q[rd_q];
  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;

  // storage, no reset needed on the data path
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= s_data;
  end

  // pointers wrap at the depth
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
  end

  // occupancy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (push && !pop)
      cnt_q <= cnt_q + 1'b1;
    else if (pop && !push)
      cnt_q <= cnt_q - 1'b1;
  end
endmodule
`default_nettype wire

// ==== hdl/sdl_core.sv ====
// serial frame receiver and converter load sequencing, device side
`timescale 1ns/1ps
`default_nettype none
module sdl_core (
  // system clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // serial link
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo,
  // control pins
  input wire logic load_strobe_n,
  input wire logic reset_pin_n,
  input wire logic crc_en,
  input wire logic slew_en,
  // converter side
  output logic [15:0] dac_code,
  output logic dac_update,
  output logic [15:0] dac_cfg,
  output logic cfg_update,
  output logic frame_drop
);
  // ==========================================================================
  // link domain, clocked by the serial clock
  // ==========================================================================
  logic [1:0] crc_sync_q;
  logic [5:0] cnt_q, flen;
  logic [31:0] rx_q, word_q, tx_q;
  logic tog_q, sdo_q;

  // crc enable is quasi-static; two falling edges settle it inside the link
  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
      crc_sync_q <= 2'h0;
    else
      crc_sync_q <= {crc_sync_q[0], crc_en};
  end

  assign flen = crc_sync_q[1] ? sdl_pkg::FRAME_LEN_CRC : sdl_pkg::FRAME_LEN;

  // bit count ends with the frame itself, since the clock may stop outside frames
  always_ff @(negedge sclk or posedge sync_n)
  begin
    if (sync_n)
      cnt_q <= 6'h00;
    else if (cnt_q != 6'h3F)
      cnt_q <= cnt_q + 6'h01; // saturates so long overruns never wrap
  end

  // shift in msb first on falling edges while the frame is open
  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
      rx_q <= 32'h00000000;
    else if (!sync_n && cnt_q < flen)
      rx_q <= {rx_q[30:0], sdi};
  end

  // capture the whole frame at its last bit and flag it by a toggle
  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_q <= 32'h00000000;
      tog_q <= 1'b0;
    end
    else if (!sync_n && cnt_q == flen - 6'h01)
    begin
      word_q <= {rx_q[30:0], sdi};
      tog_q <= ~tog_q;
    end
  end

  // readback echoes the last complete frame, left aligned at the frame length
  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
      tx_q <= 32'h00000000;
    else if (!sync_n && cnt_q == 6'h00)
      tx_q <= crc_sync_q[1] ? word_q : {word_q[23:0], 8'h00};
  end

  // output bit launched on the rising edge, zero once the frame bits are spent
  always_ff @(posedge sclk or posedge sync_n)
  begin
    if (sync_n)
      sdo_q <= 1'b0;
    else if (cnt_q < flen)
      sdo_q <= tx_q[5'(6'h1F - cnt_q)];
    else
      sdo_q <= 1'b0;
  end

  assign sdo = sdo_q;

  // ==========================================================================
  // system domain: synchronisers
  // ==========================================================================
  logic [sdl_pkg::SY_W-1:0] sy1_q, sy2_q, sy3_q;

  // pins and the frame toggle pass two flops; a third only feeds edge detection
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy1_q <= 5'h07;
      sy2_q <= 5'h07;
      sy3_q <= 5'h07;
    end
    else
    begin
      sy1_q <= {tog_q, slew_en, reset_pin_n, load_strobe_n, sync_n};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  logic sync_hi, load_lo, load_fall, pin_rst, word_arrived;

  assign sync_hi = sy2_q[sdl_pkg::SY_SYNC];
  assign load_lo = !sy2_q[sdl_pkg::SY_LOAD];
  assign load_fall = sy3_q[sdl_pkg::SY_LOAD] && !sy2_q[sdl_pkg::SY_LOAD];
  assign pin_rst = !sy2_q[sdl_pkg::SY_RSTP];
  assign word_arrived = sy3_q[sdl_pkg::SY_TOG] ^ sy2_q[sdl_pkg::SY_TOG];

  // ==========================================================================
  // frame commit into the buffer
  // ==========================================================================
  logic pend_q, drop_q, b_s_ready, b_m_valid, b_m_ready, push_req;
  logic [23:0] b_m_data;

  // the word is stable in the link for a whole frame, so it is read after the toggle
  assign push_req = pend_q && sync_hi;

  // pending word waits for frame select to rise; a new arrival beats the clear
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pend_q <= 1'b0;
    else if (word_arrived)
      pend_q <= 1'b1;
    else if (push_req && b_s_ready)
      pend_q <= 1'b0;
  end

  // a word overwritten while the buffer is full is reported, not hidden
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      drop_q <= 1'b0;
    else
      drop_q <= word_arrived && pend_q;
  end

  assign frame_drop = drop_q;

  sdl_buf2 #(
    .WIDTH(sdl_pkg::FRAME_BITS),
    .DEPTH(2)
  ) u_buf (
    .clk(mclk),
    .rst_n(nrst),
    .s_valid(push_req),
    .s_ready(b_s_ready),
    .s_data(word_q[31:8] & {24{crc_sync_q[1]}} | word_q[23:0] & {24{!crc_sync_q[1]}}),
    .m_valid(b_m_valid),
    .m_ready(b_m_ready),
    .m_data(b_m_data)
  );

  // ==========================================================================
  // converter update sequencing
  // ==========================================================================
  sdl_pkg::sdl_state_t st_q;
  logic [sdl_pkg::HOLD_W-1:0] hold_q;
  logic [15:0] in_q, code_q, cfg_q;
  logic upd_q, cfg_upd_q, pop, is_input, is_config;

  // a load edge takes priority, so a buffered word waits until the hold window it starts has ended
  assign b_m_ready = (st_q == sdl_pkg::SDL_IDLE) && !load_fall && !pin_rst;
  assign pop = b_m_valid && b_m_ready;
  assign is_input = b_m_data[sdl_pkg::ADDR_MSB:sdl_pkg::ADDR_LSB] == sdl_pkg::ADDR_DAC_INPUT;
  assign is_config = b_m_data[sdl_pkg::ADDR_MSB:sdl_pkg::ADDR_LSB] == sdl_pkg::ADDR_DAC_CONFIG;

  // hold window keeps a later word from overtaking a response in progress
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= sdl_pkg::SDL_IDLE;
      hold_q <= '0;
    end
    else
    begin
      case (st_q)
        sdl_pkg::SDL_IDLE:
        begin
          if (load_fall && !pin_rst)
          begin
            st_q <= sdl_pkg::SDL_HOLD;
            hold_q <= sy2_q[sdl_pkg::SY_SLEW] ? 6'(sdl_pkg::SLEW_RESP_CYC - 1)
                                               : 6'(sdl_pkg::LOAD_RESP_CYC - 1);
          end
          else if (pop && is_input && load_lo)
          begin
            st_q <= sdl_pkg::SDL_HOLD;
            hold_q <= 6'(sdl_pkg::TRANSP_RESP_CYC - 1);
          end
        end
        sdl_pkg::SDL_HOLD:
        begin
          if (hold_q == '0)
            st_q <= sdl_pkg::SDL_IDLE;
          else
            hold_q <= hold_q - 6'h01;
        end
        default:
          st_q <= sdl_pkg::SDL_IDLE;
      endcase
    end
  end

  // input and configuration registers, cleared by the reset pin
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_q <= sdl_pkg::DAC_CODE_RST;
      cfg_q <= sdl_pkg::DAC_CFG_RST;
      cfg_upd_q <= 1'b0;
    end
    else if (pin_rst)
    begin
      in_q <= sdl_pkg::DAC_CODE_RST;
      cfg_q <= sdl_pkg::DAC_CFG_RST;
      cfg_upd_q <= 1'b0;
    end
    else
    begin
      cfg_upd_q <= pop && is_config;
      if (pop && is_input)
        in_q <= b_m_data[sdl_pkg::DATA_MSB:sdl_pkg::DATA_LSB];
      if (pop && is_config)
        cfg_q <= b_m_data[sdl_pkg::DATA_MSB:sdl_pkg::DATA_LSB];
    end
  end

  // output register: transparent when the strobe is low, else on its falling edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_q <= sdl_pkg::DAC_CODE_RST;
      upd_q <= 1'b0;
    end
    else if (pin_rst)
    begin
      code_q <= sdl_pkg::DAC_CODE_RST;
      upd_q <= 1'b0;
    end
    else if (st_q == sdl_pkg::SDL_IDLE && load_fall)
    begin
      code_q <= in_q;
      upd_q <= 1'b1;
    end
    else if (pop && is_input && load_lo)
    begin
      code_q <= b_m_data[sdl_pkg::DATA_MSB:sdl_pkg::DATA_LSB];
      upd_q <= 1'b1;
    end
    else
      upd_q <= 1'b0;
  end

  assign dac_code = code_q;
  assign dac_update = upd_q;
  assign dac_cfg = cfg_q;
  assign cfg_update = cfg_upd_q;
endmodule
`default_nettype wire

// ==== hdl/sdl_pkg.sv ====
// shared constants for the serial frame and converter load block
package sdl_pkg;
  // frame geometry
  localparam int FRAME_BITS = 24;
  localparam int FRAME_BITS_CRC = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] FRAME_LEN = 6'h18;
  localparam logic [5:0] FRAME_LEN_CRC = 6'h20;
  // field layout of the 24-bit payload
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 0;
  localparam int DATA_W = 16;
  // register addresses carried in a frame (arbitrary plain values)
  localparam logic [7:0] ADDR_DAC_INPUT = 8'h01;
  localparam logic [7:0] ADDR_DAC_CONFIG = 8'h02;
  // reset values
  localparam logic [15:0] DAC_CODE_RST = 16'h0000;
  localparam logic [15:0] DAC_CFG_RST = 16'h0000;
  // clock rate
  localparam int MCLK_PERIOD_NS = 40;
  // longest response times, rounded down to whole cycles
  localparam int LOAD_RESP_NS = 600;
  localparam int SLEW_RESP_NS = 2000;
  localparam int TRANSP_RESP_NS = 1500;
  localparam int LOAD_RESP_CYC = LOAD_RESP_NS / MCLK_PERIOD_NS;
  localparam int SLEW_RESP_CYC = SLEW_RESP_NS / MCLK_PERIOD_NS;
  localparam int TRANSP_RESP_CYC = TRANSP_RESP_NS / MCLK_PERIOD_NS;
  localparam int HOLD_W = 6;
  // synchroniser lane positions
  localparam int SY_SYNC = 0;
  localparam int SY_LOAD = 1;
  localparam int SY_RSTP = 2;
  localparam int SY_SLEW = 3;
  localparam int SY_TOG = 4;
  localparam int SY_W = 5;
  // consumer states
  typedef enum logic [0:0] {SDL_IDLE, SDL_HOLD} sdl_state_t;
endpackage

// ==== verif/sdl_core_chk.sv ====
// assertion checker for the serial frame and converter load block
`timescale 1ns/1ps
`default_nettype none
module sdl_core_chk (
  // clocks and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sclk,
  // serial link
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic sdo,
  // control pins
  input wire logic load_strobe_n,
  input wire logic reset_pin_n,
  input wire logic crc_en,
  input wire logic slew_en,
  // converter side
  input wire logic [15:0] dac_code,
  input wire logic dac_update,
  input wire logic [15:0] dac_cfg,
  input wire logic cfg_update
);
  // ==========================================================
  // link-side mirror of the frame
  logic [5:0] cnt_q;
  logic [5:0] len;
  logic [23:0] sh_q;
  logic full_q;
  logic sdo_q;
  assign len = crc_en ? sdl_pkg::FRAME_LEN_CRC : sdl_pkg::FRAME_LEN;
  // falls per frame; frame select high clears it, as in the device
  always_ff @(negedge sclk or posedge sync_n)
    if (sync_n)
      cnt_q <= 6'h00;
    else if (cnt_q != 6'h3F)
      cnt_q <= cnt_q + 6'h01;
  // payload kept after the frame so the update checks can use it
  always_ff @(negedge sclk)
  begin
    if (cnt_q < 6'h18)
      sh_q <= {sh_q[22:0], sdi};
    full_q <= (cnt_q + 6'h01 >= len);
    sdo_q <= sdo;
  end
  sdo_zero_a: assert property (@(negedge sclk) disable iff (!nrst || sync_n)
    cnt_q >= len |-> sdo == 1'b0) else $error("sdo not zero after frame bits");
  sdo_launch_a: assert property (@(posedge sclk) disable iff (!nrst || sync_n)
    cnt_q != 6'h00 |-> sdo == sdo_q) else $error("sdo moved on a falling edge");
  sdo_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    sync_n && $past(sync_n) |-> sdo == 1'b0) else $error("sdo driven between frames");
  transp_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(sync_n) && full_q && reset_pin_n && !load_strobe_n
    && sh_q[23:16] == sdl_pkg::ADDR_DAC_INPUT |-> ##[1:37] (dac_update && dac_code == sh_q[15:0]))
    else $error("transparent update late or wrong");
  strobe_fast_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(load_strobe_n) && !slew_en |-> ##[1:15] dac_update) else $error("load too slow");
  strobe_slew_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(load_strobe_n) && slew_en |-> ##[1:50] dac_update) else $error("slewed load too slow");
  cfg_take_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(sync_n) && full_q && reset_pin_n && sh_q[23:16] == sdl_pkg::ADDR_DAC_CONFIG
    |-> ##[1:37] (cfg_update && dac_cfg == sh_q[15:0])) else $error("config word not taken");
  upd_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    dac_update |=> !dac_update) else $error("update pulse too long");
endmodule
bind sdl_core sdl_core_chk i_chk (.mclk, .nrst, .sclk, .sync_n, .sdi, .sdo, .load_strobe_n,
  .reset_pin_n, .crc_en, .slew_en, .dac_code, .dac_update, .dac_cfg, .cfg_update);
`default_nettype wire

// ==== verif/sdl_host.sv ====
// host model that clocks frames into the serial port
`timescale 1ns/1ps
`default_nettype none
module sdl_host (
  // serial link
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo
);
  // ==========================================================
  // link clock idles high and stands still between frames
  logic [39:0] rb;
  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
    rb = '0;
  end
  // nf falls, word sent msb first from bit 31; sdo kept for each fall
  task automatic frame(input logic [31:0] w, input int nb, input int nf);
    #3; // off the system clock edge, so the synchroniser never races the pin
    sync_n = 1'b0;
    #10;
    for (int k = 0; k < nf; k++)
    begin
      sdi = (k < nb) ? w[31-k] : ~sdi;
      #7.5;
      rb[k] = sdo;
      sclk = 1'b0; // exact count of falls is the caller's nf
      #7.5;
      sclk = 1'b1;
    end
    #5;
    sync_n = 1'b1; // raised 12.5 ns after the last fall
    sdi = ~sdi; // released line: no pull, so show the inverse
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the serial frame and converter load block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // signals and model state
  logic mclk, nrst, sclk, sync_n, sdi, sdo, load_strobe_n, reset_pin_n, crc_en, slew_en;
  logic [15:0] dac_code, dac_cfg, in_q, code_q, cfg_q;
  logic dac_update, cfg_update, frame_drop;
  logic [31:0] echo_q;
  int mismatches, total_checks, seed, n_du, n_cu, n_fd, fr_ok, fd;
  sdl_core i_dut (.mclk, .nrst, .sclk, .sync_n, .sdi, .sdo, .load_strobe_n, .reset_pin_n,
    .crc_en, .slew_en, .dac_code, .dac_update, .dac_cfg, .cfg_update, .frame_drop);
  sdl_host i_host (.sclk, .sync_n, .sdi, .sdo);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // pulses counted on the falling edge, where they have settled
  always @(negedge mclk)
  begin
    if (dac_update === 1'b1) n_du++;
    if (cfg_update === 1'b1) n_cu++;
    if (frame_drop === 1'b1) n_fd++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmp(input int eu, input int ec);
    chk("dac_update count", eu, n_du);
    chk("cfg_update count", ec, n_cu);
    chk("dac_code", code_q, dac_code);
    chk("dac_cfg", cfg_q, dac_cfg);
  endtask
  // one frame, readback compared, then the model's registers
  task automatic send(input logic [7:0] a, input int nf);
    logic [31:0] w;
    int len;
    int eu;
    int ec;
    len = crc_en ? 32 : 24;
    w = $random(seed);
    w[31:24] = a;
    eu = n_du;
    ec = n_cu;
    i_host.frame(w, len, nf);
    for (int k = 0; k < nf; k++)
      if (fr_ok > 2)
        chk("sdo bit", (k > 0 && k < 32) ? echo_q[31-k] : 1'b0, i_host.rb[k]);
    fr_ok++;
    if (nf >= len)
    begin
      echo_q = crc_en ? w : {w[31:8], 8'h00};
      if (a == sdl_pkg::ADDR_DAC_INPUT) in_q = w[23:8];
      if (a == sdl_pkg::ADDR_DAC_INPUT && !load_strobe_n) code_q = in_q;
      if (a == sdl_pkg::ADDR_DAC_INPUT && !load_strobe_n) eu++;
      if (a == sdl_pkg::ADDR_DAC_CONFIG) cfg_q = w[23:8];
      if (a == sdl_pkg::ADDR_DAC_CONFIG && reset_pin_n) ec++;
    end
    cyc(a == sdl_pkg::ADDR_DAC_CONFIG ? 12600 : 80);
    cmp(eu, ec);
  endtask
  // strobe held 60 cycles so the pulse is well over its minimum width
  task automatic strobe(input logic lvl);
    int eu;
    eu = n_du + (lvl ? 0 : 1);
    load_strobe_n <= lvl;
    if (!lvl) code_q = in_q;
    cyc(60);
    cmp(eu, n_cu);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    cyc(100000);
    mismatches++;
    $display("mismatch run length expected end seen timeout");
    stop_test();
  end
  initial
  begin
    seed = 32'h330C;
    {nrst, crc_en, slew_en} = 3'h0;
    {load_strobe_n, reset_pin_n} = 2'h3;
    {echo_q, in_q, code_q, cfg_q} = '0;
    fr_ok = 3;
    cyc(3);
    nrst <= 1'b1;
    cyc(2600);
    cmp(0, 0);
    $display("test reset done");
    send(sdl_pkg::ADDR_DAC_INPUT, 24);
    strobe(1'b0);
    send(sdl_pkg::ADDR_DAC_INPUT, 28);
    strobe(1'b1);
    $display("test load paths done");
    send(sdl_pkg::ADDR_DAC_INPUT, 20);
    slew_en <= 1'b1;
    strobe(1'b0);
    strobe(1'b1);
    slew_en <= 1'b0;
    send(sdl_pkg::ADDR_DAC_CONFIG, 24);
    repeat (4) send(($random(seed) & 1) ? 8'hFF : 8'h01, 24 + ($unsigned($random(seed)) % 8));
    $display("test short, config and random frames done");
    crc_en <= 1'b1;
    cyc(1); // let the new length settle before the model reads it
    fr_ok = 0;
    repeat (3) send(8'hFF, 32);
    send(sdl_pkg::ADDR_DAC_INPUT, 34);
    send(sdl_pkg::ADDR_DAC_CONFIG, 32);
    crc_en <= 1'b0;
    cyc(1); // let the new length settle before the model reads it
    fr_ok = 0;
    repeat (3) send(8'hFF, 24);
    $display("test crc frames done");
    reset_pin_n <= 1'b0;
    {in_q, code_q, cfg_q} = '0;
    cyc(130);
    fd = n_fd;
    repeat (4) send(sdl_pkg::ADDR_DAC_INPUT, 24);
    chk("frame_drop count", 32'h00000001, n_fd - fd);
    reset_pin_n <= 1'b1;
    cyc(2600);
    strobe(1'b0);
    strobe(1'b1);
    $display("test buffer overflow done");
    stop_test();
  end
endmodule
`default_nettype wire
